//--- src/acmsc_pkg.sv
// Package: constants and types for the capacity, multiple and sleep command block
`default_nettype none
package acmsc_pkg;
  // ****************************************
  // Register bus
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] REG_FEATURE = 4'h0;  // W feature, R error
  localparam logic [3:0] REG_SECCNT = 4'h1;
  localparam logic [3:0] REG_LBA_LOW = 4'h2;
  localparam logic [3:0] REG_LBA_MID = 4'h3;
  localparam logic [3:0] REG_LBA_HIGH = 4'h4;
  localparam logic [3:0] REG_DRVHEAD = 4'h5;
  localparam logic [3:0] REG_COMMAND = 4'h6;  // W command, R status
  localparam logic [3:0] REG_DEVCTL = 4'h7;
  localparam logic [3:0] REG_INT_STATUS = 4'h8;
  localparam logic [3:0] REG_INT_CLEAR = 4'h9;
  localparam logic [3:0] REG_INT_ENABLE = 4'hA;
  localparam logic [3:0] REG_MAX_LO = 4'hB;
  localparam logic [3:0] REG_MAX_HI = 4'hC;
  localparam logic [3:0] REG_MULTI = 4'hD;
  localparam logic [3:0] REG_IDENT_W82 = 4'hE;
  localparam logic [3:0] REG_MODE = 4'hF;
  localparam int TF_N = 5;  // Feature, count, low, mid, high
  // ****************************************
  // Command and feature codes
  // ****************************************
  localparam logic [7:0] CMD_NATIVE_MAX = 8'hF8;
  localparam logic [7:0] CMD_SET_MAX = 8'hF9;
  localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
  localparam logic [7:0] CMD_SET_MULTI = 8'hC6;
  localparam logic [7:0] CMD_SLEEP_A = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B = 8'hE6;
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] FT_PLAIN = 8'h00;
  localparam logic [7:0] FT_PASSWORD = 8'h01;
  localparam logic [7:0] FT_LOCK = 8'h02;
  localparam logic [7:0] FT_UNLOCK = 8'h03;
  localparam logic [7:0] FT_FREEZE = 8'h04;
  localparam logic [7:0] SF_POR_DIS = 8'h66;
  localparam logic [7:0] SF_POR_EN = 8'hCC;
  localparam logic [7:0] SMART_SIG_HI = 8'hC2;
  localparam logic [7:0] SMART_SIG_LO = 8'h4F;
  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DEV_BIT = 4;
  localparam int SC_VV_BIT = 0;
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int DC_SRST = 2;
  localparam int EV_DONE = 0;
  localparam int EV_ABRT = 1;
  localparam int EV_NVWR = 2;
  localparam int EV_W = 3;
  localparam logic [15:0] IDENT_W82_VAL = 16'h0001;  // Bit 0: self-monitoring
  localparam logic [1:0] INIT_DONE = 2'h3;
  // Controller states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } acmsc_state_t;
endpackage : acmsc_pkg
`default_nettype wire

//--- src/acmsc_evt_if.sv
// Interface: events and interrupt registers between controller and interrupt unit
`default_nettype none
interface acmsc_evt_if;
  import acmsc_pkg::*;
  logic [EV_W-1:0] evt;  // Event pulses
  logic [EV_W-1:0] clr;  // Clear mask, one cycle
  logic en_wr;  // Enable register write
  logic [EV_W-1:0] en_data;  // Enable write data
  logic [EV_W-1:0] status;  // Sticky status
  logic [EV_W-1:0] enable;  // Enable register
  logic irq;  // Level interrupt
  modport ctl (output evt, clr, en_wr, en_data, input status, enable, irq);
  modport irqu (input evt, clr, en_wr, en_data, output status, enable, irq);
endinterface : acmsc_evt_if
`default_nettype wire

//--- src/acmsc_irq.sv
// Module: sticky event status, enable mask and level interrupt
`default_nettype none
module acmsc_irq
  import acmsc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  acmsc_evt_if.irqu ev
);
  logic [EV_W-1:0] status_q;  // Sticky status
  logic [EV_W-1:0] status_d;
  logic [EV_W-1:0] enable_q;  // Enable mask
  logic [EV_W-1:0] enable_d;
  logic irq_q;  // Registered interrupt
  logic irq_d;

  // Next values: a set in the clear cycle wins
  always_comb begin
    status_d = (status_q & ~ev.clr) | ev.evt;
    enable_d = ev.en_wr ? ev.en_data : enable_q;
    irq_d = |(status_d & enable_d);
  end

  // Registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      status_q <= '0;
      enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q <= irq_d;
    end
  end

  assign ev.status = status_q;
  assign ev.enable = enable_q;
  assign ev.irq = irq_q;
endmodule : acmsc_irq
`default_nettype wire

//--- src/acmsc_core.sv
// Module: task-file command decode and execution for capacity, multiple and sleep
//
// The register addresses and the strobed register port were chosen for this implementation.
`default_nettype none
// Notes on behaviour
// - F9h replaces max address with 28-bit value
// - Act only when device select matches
// - Count bit 0 selects non-volatile retention
// - Feature code picks password, lock, unlock, freeze
// - Abort second non-volatile set-max after reset
// - 37h uses previous and current register bytes
// - C6h sets busy, checks sector count
// - Valid count stored, multiple commands enabled
// - Unsupported count aborts, disables multiple
// - Zero count disables multiple commands
// - Multiple commands disabled after power-on
// - Sleep: busy, enter sleep, interrupt at once
// - Any further command leaves sleep
// - Identify word 82 bit 0 advertises SMART
// - Soft reset restores defaults unless disabled
module acmsc_core
  import acmsc_pkg::*;
#(
  parameter logic DEV_ID = 1'b0,  // Device select value answered
  parameter logic [7:0] MULTI_MAX = 8'h10  // Largest block count
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [47:0] nv_max_in,  // Stored non-volatile max
  output logic [DATA_W-1:0] rdata_out,
  output logic irq_out,
  output logic busy_out,
  output logic sleep_out,
  output logic [47:0] nv_max_out,
  output logic nv_wr_out,
  output logic smart_req_out,
  output logic [7:0] smart_feature_out
);
  // ****************************************
  // State
  // ****************************************
  acmsc_state_t state_q, state_d;
  logic [7:0] tf_cur_q [TF_N], tf_cur_d [TF_N];  // Current bytes
  logic [7:0] tf_prev_q [TF_N], tf_prev_d [TF_N];  // Previous bytes
  logic [7:0] dh_q, dh_d;  // Drive/head
  logic [7:0] cmd_q, cmd_d;  // Latched command
  logic err_q, err_d;  // Aborted flag
  logic [47:0] max_q, max_d;  // Current max address
  logic multi_en_q, multi_en_d;
  logic [7:0] multi_cnt_q, multi_cnt_d;
  logic sleep_q, sleep_d;
  logic native_ok_q, native_ok_d;  // Native max just read
  logic nv_done_q, nv_done_d;  // Non-volatile set since reset
  logic lock_q, lock_d;
  logic frozen_q, frozen_d;
  logic pw_set_q, pw_set_d;
  logic por_def_q, por_def_d;  // Soft reset restores defaults
  logic [47:0] nv_s1_q, nv_s2_q;  // Strap synchroniser
  logic [1:0] init_q, init_d;  // Strap capture count
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [47:0] nv_max_q, nv_max_d;
  logic nv_wr_q, nv_wr_d;
  logic smart_q, smart_d;
  logic [7:0] smart_ft_q, smart_ft_d;
  logic [EV_W-1:0] evt_d;
  logic accept_w;  // Command taken
  logic abort_w;
  logic [47:0] addr28_w, addr48_w;
  logic cnt_ok_w;

  acmsc_evt_if ev ();

  // ****************************************
  // Interrupt unit
  // ****************************************
  acmsc_irq u_irq (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ev(ev)
  );

  // Addresses and count check
  always_comb begin
    addr28_w = {20'h00000, dh_q[3:0], tf_cur_q[4], tf_cur_q[3], tf_cur_q[2]};
    addr48_w = {tf_prev_q[4], tf_prev_q[3], tf_prev_q[2],
                tf_cur_q[4], tf_cur_q[3], tf_cur_q[2]};
    cnt_ok_w = (tf_cur_q[1] <= MULTI_MAX) && ((tf_cur_q[1] & (tf_cur_q[1] - 8'h01)) == 8'h00);
    accept_w = wr_in && (addr_in == REG_COMMAND) && (state_q == ST_IDLE) &&
               (init_q == INIT_DONE) && (dh_q[DH_DEV_BIT] == DEV_ID);
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_d = state_q;
    tf_cur_d = tf_cur_q;
    tf_prev_d = tf_prev_q;
    dh_d = dh_q;
    cmd_d = cmd_q;
    err_d = err_q;
    max_d = max_q;
    multi_en_d = multi_en_q;
    multi_cnt_d = multi_cnt_q;
    sleep_d = sleep_q;
    native_ok_d = native_ok_q;
    nv_done_d = nv_done_q;
    lock_d = lock_q;
    frozen_d = frozen_q;
    pw_set_d = pw_set_q;
    por_def_d = por_def_q;
    init_d = (init_q == INIT_DONE) ? init_q : init_q + 2'h1;
    nv_max_d = nv_max_q;
    nv_wr_d = 1'b0;
    smart_d = 1'b0;
    smart_ft_d = smart_ft_q;
    evt_d = '0;
    abort_w = 1'b0;
    // Strap load of max until synchroniser settles
    if (init_q != INIT_DONE) begin
      max_d = nv_s2_q;
    end
    // Task-file writes, ignored while busy; old byte kept as previous
    for (int i = 0; i < TF_N; i++) begin
      if (wr_in && state_q == ST_IDLE && addr_in == 4'(i)) begin
        tf_prev_d[i] = tf_cur_q[i];
        tf_cur_d[i] = wdata_in[7:0];
      end
    end
    if (wr_in && state_q == ST_IDLE && addr_in == REG_DRVHEAD) begin
      dh_d = wdata_in[7:0];
    end
    // Command taken: busy next cycle, sleep left
    if (accept_w) begin
      cmd_d = wdata_in[7:0];
      state_d = ST_EXEC;
      err_d = 1'b0;
      sleep_d = 1'b0;
    end
    // Execution, one busy cycle
    if (state_q == ST_EXEC) begin
      state_d = ST_IDLE;
      native_ok_d = 1'b0;
      unique case (cmd_q)
        CMD_NATIVE_MAX: begin
          native_ok_d = 1'b1;
        end
        CMD_SET_MAX, CMD_SET_MAX_EXT: begin
          if (!native_ok_q || !dh_q[DH_LBA_BIT]) begin
            abort_w = 1'b1;
          end else if (cmd_q == CMD_SET_MAX_EXT || tf_cur_q[0] == FT_PLAIN) begin
            if (lock_q) begin
              abort_w = 1'b1;
            end else if (tf_cur_q[1][SC_VV_BIT] && nv_done_q) begin
              abort_w = 1'b1;
            end else begin
              max_d = (cmd_q == CMD_SET_MAX) ? addr28_w : addr48_w;
              if (tf_cur_q[1][SC_VV_BIT]) begin
                nv_max_d = max_d;
                nv_wr_d = 1'b1;
                nv_done_d = 1'b1;
                evt_d[EV_NVWR] = 1'b1;
              end
            end
          end else if (tf_cur_q[0] == FT_FREEZE) begin
            frozen_d = 1'b1;
          end else if (frozen_q || tf_cur_q[0] > FT_FREEZE) begin
            abort_w = 1'b1;
          end else if (tf_cur_q[0] == FT_PASSWORD) begin
            pw_set_d = 1'b1;
          end else begin
            lock_d = (tf_cur_q[0] == FT_LOCK);
          end
        end
        CMD_SET_MULTI: begin
          if (tf_cur_q[1] == 8'h00) begin
            multi_en_d = 1'b0;
          end else if (cnt_ok_w) begin
            multi_en_d = 1'b1;
            multi_cnt_d = tf_cur_q[1];
          end else begin
            multi_en_d = 1'b0;
            abort_w = 1'b1;
          end
        end
        CMD_SLEEP_A, CMD_SLEEP_B: begin
          sleep_d = 1'b1;
        end
        CMD_SMART: begin
          if (tf_cur_q[4] != SMART_SIG_HI || tf_cur_q[3] != SMART_SIG_LO) begin
            abort_w = 1'b1;
          end else begin
            smart_d = 1'b1;
            smart_ft_d = tf_cur_q[0];
          end
        end
        CMD_SET_FEAT: begin
          if (tf_cur_q[0] == SF_POR_DIS) begin
            por_def_d = 1'b0;
          end else if (tf_cur_q[0] == SF_POR_EN) begin
            por_def_d = 1'b1;
          end
        end
        default: begin
          abort_w = 1'b1;
        end
      endcase
      err_d = abort_w;
      evt_d[EV_DONE] = 1'b1;
      evt_d[EV_ABRT] = abort_w;
    end
    // Soft reset: cancel command, defaults unless disabled
    if (wr_in && addr_in == REG_DEVCTL && wdata_in[DC_SRST]) begin
      state_d = ST_IDLE;
      err_d = 1'b0;
      sleep_d = 1'b0;
      native_ok_d = 1'b0;
      if (por_def_q) begin
        multi_en_d = 1'b0;
        multi_cnt_d = 8'h00;
      end
    end
  end

  // Read mux, data valid the cycle after the strobe only
  always_comb begin
    rdata_d = '0;
    if (rd_in) begin
      unique case (addr_in)
        REG_FEATURE: rdata_d[ER_ABRT] = err_q;
        REG_SECCNT, REG_LBA_LOW, REG_LBA_MID, REG_LBA_HIGH: begin
          rdata_d[7:0] = tf_cur_q[addr_in[2:0]];
        end
        REG_DRVHEAD: rdata_d[7:0] = dh_q;
        REG_COMMAND: begin
          rdata_d[ST_BSY] = (state_q == ST_EXEC);
          rdata_d[ST_DRDY] = (init_q == INIT_DONE);
          rdata_d[ST_ERR] = err_q;
        end
        REG_INT_STATUS: rdata_d[EV_W-1:0] = ev.status;
        REG_INT_ENABLE: rdata_d[EV_W-1:0] = ev.enable;
        REG_MAX_LO: rdata_d[23:0] = max_q[23:0];
        REG_MAX_HI: rdata_d[23:0] = max_q[47:24];
        REG_MULTI: rdata_d[8:0] = {multi_en_q, multi_cnt_q};
        REG_IDENT_W82: rdata_d[15:0] = IDENT_W82_VAL;
        REG_MODE: rdata_d[4:0] = {por_def_q, pw_set_q, frozen_q, lock_q, sleep_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // Interrupt unit hookup
  assign ev.evt = evt_d;
  assign ev.clr = (wr_in && addr_in == REG_INT_CLEAR) ? wdata_in[EV_W-1:0] : '0;
  assign ev.en_wr = wr_in && (addr_in == REG_INT_ENABLE);
  assign ev.en_data = wdata_in[EV_W-1:0];

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    nv_s1_q <= nv_max_in;
    nv_s2_q <= nv_s1_q;
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      for (int i = 0; i < TF_N; i++) begin
        tf_cur_q[i] <= 8'h00;
        tf_prev_q[i] <= 8'h00;
      end
      dh_q <= 8'h00;
      cmd_q <= 8'h00;
      err_q <= 1'b0;
      max_q <= 48'h000000000000;
      multi_en_q <= 1'b0;
      multi_cnt_q <= 8'h00;
      sleep_q <= 1'b0;
      native_ok_q <= 1'b0;
      nv_done_q <= 1'b0;
      lock_q <= 1'b0;
      frozen_q <= 1'b0;
      pw_set_q <= 1'b0;
      por_def_q <= 1'b1;
      init_q <= 2'h0;
      rdata_q <= '0;
      nv_max_q <= 48'h000000000000;
      nv_wr_q <= 1'b0;
      smart_q <= 1'b0;
      smart_ft_q <= 8'h00;
    end else begin
      state_q <= state_d;
      tf_cur_q <= tf_cur_d;
      tf_prev_q <= tf_prev_d;
      dh_q <= dh_d;
      cmd_q <= cmd_d;
      err_q <= err_d;
      max_q <= max_d;
      multi_en_q <= multi_en_d;
      multi_cnt_q <= multi_cnt_d;
      sleep_q <= sleep_d;
      native_ok_q <= native_ok_d;
      nv_done_q <= nv_done_d;
      lock_q <= lock_d;
      frozen_q <= frozen_d;
      pw_set_q <= pw_set_d;
      por_def_q <= por_def_d;
      init_q <= init_d;
      rdata_q <= rdata_d;
      nv_max_q <= nv_max_d;
      nv_wr_q <= nv_wr_d;
      smart_q <= smart_d;
      smart_ft_q <= smart_ft_d;
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out = ev.irq;
  assign busy_out = state_q[1];
  assign sleep_out = sleep_q;
  assign nv_max_out = nv_max_q;
  assign nv_wr_out = nv_wr_q;
  assign smart_req_out = smart_q;
  assign smart_feature_out = smart_ft_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic exec_w;
  assign exec_w = (state_q == ST_EXEC);

  chk_busy_one_cycle: assert property (accept_w |=> busy_out ##1 !busy_out)
    else $error("busy not exactly one cycle");
  chk_devsel_ignore: assert property (wr_in && addr_in == REG_COMMAND && !busy_out &&
    dh_q[DH_DEV_BIT] != DEV_ID && !(wr_in && addr_in == REG_DEVCTL) |=> !busy_out)
    else $error("command for other device taken");
  chk_sleep_enter: assert property (exec_w &&
    (cmd_q == CMD_SLEEP_A || cmd_q == CMD_SLEEP_B) && !(wr_in && addr_in == REG_DEVCTL)
    |=> sleep_out && !busy_out && ev.status[EV_DONE])
    else $error("sleep not entered with completion");
  chk_sleep_leave: assert property (accept_w |=> !sleep_out)
    else $error("sleep kept after command");
  chk_multi_zero: assert property (exec_w && cmd_q == CMD_SET_MULTI &&
    tf_cur_q[1] == 8'h00 |=> !multi_en_q && !err_q)
    else $error("zero count left multiple on");
  chk_multi_bad: assert property (exec_w && cmd_q == CMD_SET_MULTI &&
    tf_cur_q[1] != 8'h00 && !cnt_ok_w && !(wr_in && addr_in == REG_DEVCTL)
    |=> !multi_en_q && err_q)
    else $error("bad count not aborted");
  chk_multi_good: assert property (exec_w && cmd_q == CMD_SET_MULTI &&
    tf_cur_q[1] != 8'h00 && cnt_ok_w && !(wr_in && addr_in == REG_DEVCTL)
    |=> multi_en_q && multi_cnt_q == $past(tf_cur_q[1]))
    else $error("good count not stored");
  chk_max_update: assert property (exec_w && cmd_q == CMD_SET_MAX && !abort_w &&
    tf_cur_q[0] == FT_PLAIN |=> max_q == $past(addr28_w))
    else $error("max address not replaced");
  chk_nv_second: assert property (exec_w && nv_done_q && !lock_q && native_ok_q &&
    dh_q[DH_LBA_BIT] && tf_cur_q[1][SC_VV_BIT] && (cmd_q == CMD_SET_MAX_EXT ||
    (cmd_q == CMD_SET_MAX && tf_cur_q[0] == FT_PLAIN)) &&
    !(wr_in && addr_in == REG_DEVCTL) |=> err_q && !nv_wr_out)
    else $error("second non-volatile set not aborted");
  cov_sleep: cover property (exec_w && cmd_q == CMD_SLEEP_B);
  cov_multi_on: cover property (exec_w && cmd_q == CMD_SET_MULTI ##1 multi_en_q);
  cov_nv_write: cover property (nv_wr_out);
  cov_smart: cover property (smart_req_out);
endmodule : acmsc_core
`default_nettype wire

//--- dv/acmsc_host.sv
// Host controller model: drives the register port and issues task-file commands
`default_nettype none
module acmsc_host
  import acmsc_pkg::*;
(
  input wire logic clock_in,
  input wire logic [DATA_W-1:0] rdata_in,
  input wire logic busy_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_seen;  // Busy in the cycle after the last write
  logic [DATA_W-1:0] rd_val;  // Answer of the last read
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    addr_out = '0;
    wdata_out = '0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    busy_seen = 1'b0;
    rd_val = '0;
  end
  // One-cycle write; a released bus shows the inverse of its last value
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= {24'h0, d};
    @(posedge clock_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~{24'h0, d};
    #1;
    busy_seen = busy_in;
  endtask : wr
  // One-cycle read; the answer stands only in the next cycle
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    rd_val = rdata_in;
  endtask : rd
  // ****************************************
  // Command sequences
  // ****************************************
  // Drive/head first, native-max read only when pre is set, then the rest of the 28-bit address over three registers
  task automatic set_max28(input logic [27:0] a, input logic [7:0] ft, input logic vv,
                           input logic pre);
    wr(REG_DRVHEAD, {4'hE, a[27:24]});
    if (pre) begin
      wr(REG_COMMAND, CMD_NATIVE_MAX);
    end
    wr(REG_FEATURE, ft);
    wr(REG_SECCNT, {7'h0, vv});
    wr(REG_LBA_LOW, a[7:0]);
    wr(REG_LBA_MID, a[15:8]);
    wr(REG_LBA_HIGH, a[23:16]);
    wr(REG_COMMAND, CMD_SET_MAX);
  endtask : set_max28
  // Upper address bytes go first, lower bytes second
  task automatic set_max48(input logic [47:0] a, input logic vv);
    wr(REG_DRVHEAD, 8'hE0);
    wr(REG_COMMAND, CMD_NATIVE_MAX);
    wr(REG_SECCNT, {7'h0, vv});
    for (int i = 0; i < 2; i++) begin
      wr(REG_LBA_LOW, a[24*(1-i) +: 8]);
      wr(REG_LBA_MID, a[24*(1-i)+8 +: 8]);
      wr(REG_LBA_HIGH, a[24*(1-i)+16 +: 8]);
    end
    wr(REG_COMMAND, CMD_SET_MAX_EXT);
  endtask : set_max48
  // Self-monitoring command with its signature bytes
  task automatic smart(input logic [7:0] ft, input logic [7:0] sig_hi);
    wr(REG_FEATURE, ft);
    wr(REG_LBA_MID, SMART_SIG_LO);
    wr(REG_LBA_HIGH, sig_hi);
    wr(REG_COMMAND, CMD_SMART);
  endtask : smart
endmodule : acmsc_host
`default_nettype wire

//--- dv/test_ata_capacity_multiple_sleep_cmds.sv
// Testbench: host model, reference model and checks for the command block
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %0h want %0h", $time, (a), (b)); end end
module test_ata_capacity_multiple_sleep_cmds
  import acmsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MMAX = 8'h10;  // Largest block count
  logic clock_in, rst_n_in;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic wr, rd, irq_out, busy_out, sleep_out, nv_wr_out, smart_req_out;
  logic [47:0] nv_store, nv_max_out;  // Outside storage of the saved max
  logic [7:0] smart_ft;
  // Reference model state
  logic [47:0] max_m, nv_m;
  logic [2:0] int_en_m;
  int nv_n, smart_n, num_errors, checks_done;
  logic [31:0] seed = 32'hD8B2;
  logic [31:0] r;
  logic [7:0] n;
  logic ok;
  logic [7:0] mc_tab [5] = '{8'h00, 8'h01, 8'h10, 8'h20, 8'h03};
  logic [7:0] ft_tab [9] = '{FT_PASSWORD, FT_LOCK, FT_PLAIN, FT_UNLOCK, FT_PLAIN, 8'h05,
                             FT_FREEZE, FT_LOCK, 8'hFF};
  logic [8:0] ab_tab = 9'b110100100;  // Abort expected per feature step
  // ****************************************
  // Instances and clock
  // ****************************************
  acmsc_host host (.clock_in(clock_in), .rdata_in(rdata), .busy_in(busy_out),
                   .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  acmsc_core #(.DEV_ID(1'b0), .MULTI_MAX(MMAX)) dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .nv_max_in(nv_store), .rdata_out(rdata), .irq_out(irq_out), .busy_out(busy_out),
    .sleep_out(sleep_out), .nv_max_out(nv_max_out), .nv_wr_out(nv_wr_out),
    .smart_req_out(smart_req_out), .smart_feature_out(smart_ft));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Storage takes each save pulse; pulses are counted
  always @(posedge clock_in) begin
    if (nv_wr_out === 1'b1) begin
      nv_store <= nv_max_out;
      nv_n++;
    end
    if (smart_req_out === 1'b1) begin
      smart_n++;
    end
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clock_in);
    num_errors++;
    wrap_up();
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // Hardware reset, then a bounded wait for ready
  task automatic hw_reset();
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      host.rd(REG_COMMAND);
      if (host.rd_val[ST_DRDY] === 1'b1) break;
    end
    if (host.rd_val[ST_DRDY] !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    max_m = nv_m;
    int_en_m = 3'h0;
  endtask : hw_reset
  // Read and clear the event status, checking interrupt and error on the way
  task automatic check_st(input logic [2:0] exp);
    repeat (3) @(posedge clock_in);
    host.rd(REG_INT_STATUS);
    `CHK(host.rd_val[2:0], exp)
    `CHK(irq_out, |(exp & int_en_m))
    if (exp[0]) begin
      host.rd(REG_FEATURE);
      `CHK(host.rd_val[ER_ABRT], exp[1])
    end
    host.wr(REG_INT_CLEAR, 8'h07);
  endtask : check_st
  task automatic cmd(input logic [7:0] c, input logic [2:0] exp);
    host.wr(REG_COMMAND, c);
    `CHK(host.busy_seen, exp[0])
    check_st(exp);
  endtask : cmd
  task automatic chk_max();
    host.rd(REG_MAX_LO);
    `CHK(host.rd_val[23:0], max_m[23:0])
    host.rd(REG_MAX_HI);
    `CHK(host.rd_val[23:0], max_m[47:24])
  endtask : chk_max
  task automatic chk_multi(input logic en, input logic [7:0] c);
    host.rd(REG_MULTI);
    `CHK(host.rd_val[8], en)
    if (en) begin
      `CHK(host.rd_val[7:0], c)
    end
  endtask : chk_multi
  task automatic soft_reset();
    host.wr(REG_DEVCTL, 8'h04);
    host.wr(REG_DEVCTL, 8'h00);
    repeat (4) @(posedge clock_in);
  endtask : soft_reset
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    nv_n = 0;
    smart_n = 0;
    num_errors = 0;
    checks_done = 0;
    r = rnd();
    nv_store = {r[15:0], rnd()};
    nv_m = nv_store;
    hw_reset();
    chk_multi(1'b0, 8'h00);
    host.rd(REG_IDENT_W82);
    `CHK(host.rd_val[0], 1'b1)
    chk_max();
    // Sleep with interrupt masked, then enabled; any command wakes
    host.wr(REG_DRVHEAD, 8'hE0);
    cmd(CMD_SLEEP_A, 3'b001);
    `CHK(sleep_out, 1'b1)
    host.wr(REG_INT_ENABLE, 8'h07);
    int_en_m = 3'h7;
    host.rd(REG_INT_ENABLE);
    `CHK(host.rd_val[2:0], int_en_m)
    cmd(CMD_SLEEP_B, 3'b001);
    `CHK(sleep_out, 1'b1)
    cmd(CMD_NATIVE_MAX, 3'b001);
    `CHK(sleep_out, 1'b0)
    cmd(8'h00, 3'b011);
    host.wr(REG_DRVHEAD, 8'hF0);
    cmd(CMD_SET_MAX, 3'b000);
    host.wr(REG_DRVHEAD, 8'hE0);
    // Block counts: zero, boundaries, unsupported and random
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      n = (i < 5) ? mc_tab[i] : r[7:0];
      ok = (n != 8'h00) && ((n & (n - 8'h01)) == 8'h00) && (n <= MMAX);
      host.wr(REG_SECCNT, n);
      cmd(CMD_SET_MULTI, {1'b0, ~ok & (n != 8'h00), 1'b1});
      chk_multi(ok, n);
    end
    // Soft reset restores defaults unless that is switched off
    host.wr(REG_SECCNT, 8'h04);
    cmd(CMD_SET_MULTI, 3'b001);
    soft_reset();
    chk_multi(1'b0, 8'h00);
    host.wr(REG_FEATURE, SF_POR_DIS);
    cmd(CMD_SET_FEAT, 3'b001);
    host.wr(REG_SECCNT, 8'h08);
    cmd(CMD_SET_MULTI, 3'b001);
    soft_reset();
    chk_multi(1'b1, 8'h08);
    host.wr(REG_FEATURE, SF_POR_EN);
    cmd(CMD_SET_FEAT, 3'b001);
    // Self-monitoring with good and bad signature
    host.smart(8'hD0, SMART_SIG_HI);
    check_st(3'b001);
    `CHK(smart_n, 1)
    `CHK(smart_ft, 8'hD0)
    host.smart(8'hD1, 8'h00);
    check_st(3'b011);
    `CHK(smart_n, 1)
    // Set max: missing prerequisite, saved, second save, 48-bit
    r = rnd();
    host.set_max28(r[27:0], FT_PLAIN, 1'b0, 1'b0);
    check_st(3'b011);
    r = rnd();
    host.set_max28(r[27:0], FT_PLAIN, 1'b1, 1'b1);
    max_m = {20'h0, r[27:0]};
    nv_m = max_m;
    check_st(3'b101);
    `CHK(nv_n, 1)
    `CHK(nv_max_out, nv_m)
    chk_max();
    r = rnd();
    host.set_max28(r[27:0], FT_PLAIN, 1'b1, 1'b1);
    check_st(3'b011);
    `CHK(nv_n, 1)
    r = rnd();
    host.set_max48({r[15:0], rnd()}, 1'b0);
    max_m = {r[15:0], seed};
    check_st(3'b001);
    chk_max();
    // Lock subfunctions in order
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      host.set_max28(r[27:0], ft_tab[i], 1'b0, 1'b1);
      check_st({1'b0, ab_tab[i], 1'b1});
      if (ft_tab[i] == FT_PLAIN && !ab_tab[i]) begin
        max_m = {20'h0, r[27:0]};
      end
    end
    chk_max();
    // Volatile max is lost, saved max returns; a new save is allowed
    hw_reset();
    chk_max();
    chk_multi(1'b0, 8'h00);
    r = rnd();
    host.set_max28(r[27:0], FT_PLAIN, 1'b1, 1'b1);
    check_st(3'b101);
    `CHK(nv_n, 2)
    wrap_up();
  end
endmodule : test_ata_capacity_multiple_sleep_cmds
`default_nettype wire
